/* src/msi_cfg_if.sv */
// Interface carrying the configuration load between top and store.
// Assumes both ends share ref_clk_i.
`timescale 1ns/1ps
interface msi_cfg_if;
   import msi_pkg::*;
   logic load;
   logic [CFG_W-1:0] wdata;
   logic [CFG_W-1:0] rdata;
   modport ctrl (output load, output wdata, input rdata);
   modport store (input load, input wdata, output rdata);
endinterface

/* src/msi_cfg_store.sv */
// Holds the configuration word fetched from external memory.
// Assumes loads come from the top on the same clock.
`timescale 1ns/1ps
module msi_cfg_store
   import msi_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   msi_cfg_if.store cfg
);
   typedef struct packed {
      logic [CFG_W-1:0] word;
   } msi_store_s;
   msi_store_s r, next_r;

   // Capture on load; data come out of the register
   always_comb begin
      next_r = r;
      if (cfg.load) begin
         next_r.word = cfg.wdata;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         r <= '{word: CFG_RESET_VALUE};
      end else begin
         r <= next_r;
      end
   end

   assign cfg.rdata = r.word;
endmodule // msi_cfg_store

/* src/msi_pkg.sv */
// Package for the mode select and send-immediate block.
// Assumes a single 125 MHz clock; shared by the top and its config store.
package msi_pkg;
   // Interface modes
   typedef enum logic [3:0] {
      MSI_MODE_UART,
      MSI_MODE_ASYNC_FIFO,
      MSI_MODE_SYNC_FIFO,
      MSI_MODE_CPU_FIFO,
      MSI_MODE_HALF_DUPLEX,
      MSI_MODE_FAST_SERIAL,
      MSI_MODE_ASYNC_BITBANG,
      MSI_MODE_SYNC_BITBANG,
      MSI_MODE_SERIAL_ENGINE
   } msi_mode_e;

   // Configuration word layout (read from external configuration memory)
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_MODE_W = 3;
   localparam int CFG_DRIVE_LSB = 3;
   localparam int CFG_SLEW_BIT = 5;
   localparam int CFG_SCHMITT_BIT = 6;
   localparam int CFG_PULLDN_BIT = 7;
   localparam int CFG_W = 8;
   // Configuration mode field codes
   localparam logic [2:0] CFG_SEL_UART = 3'h0;
   localparam logic [2:0] CFG_SEL_FIFO = 3'h1;
   localparam logic [2:0] CFG_SEL_CPU = 3'h2;
   localparam logic [2:0] CFG_SEL_HALF = 3'h3;
   localparam logic [2:0] CFG_SEL_FAST = 3'h4;
   localparam logic [CFG_W-1:0] CFG_RESET_VALUE = 8'h00;

   // Host bit-mode command values
   localparam logic [7:0] BM_RESET = 8'h00;
   localparam logic [7:0] BM_ASYNC_BB = 8'h01;
   localparam logic [7:0] BM_SERIAL_ENGINE = 8'h02;
   localparam logic [7:0] BM_SYNC_BB = 8'h04;
   localparam logic [7:0] BM_FS_HOLD = 8'h10;
   localparam logic [7:0] BM_SYNC_FIFO = 8'h40;

   // Avalon register offsets (byte addresses)
   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_BITMODE = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_SUSPEND = 4'hc;
   localparam logic [31:0] REG_UNMAPPED = 32'h0000_0000;

   // Timing
   localparam int CLK_MHZ = 125;
   localparam int FLUSH_PULSE_NS = 250;
   localparam int WAKE_PULSE_MS = 20;
   // Least low time that counts as a wake request, in clock cycles
   localparam int WAKE_CYCLES = WAKE_PULSE_MS * 1000 * CLK_MHZ;
   localparam int CNT_W = 22;
   // Cycles to fetch the configuration word after reset
   localparam int LOAD_CYCLES = 4;
endpackage

/* src/msi_top.sv */
// Mode selection and send-immediate/wake-up handling for one bridge channel.
// Assumes an Avalon-MM master on ref_clk_i and a config memory word on cfg_word_i.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps

// Functional notes
// - Flush/wake input honoured only in FIFO or bit-bang modes.
// - Flush request pushes buffered data out as a short packet now.
// - Falling edge of flush/wake input is the flush request.
// - No wake from suspend while pin pull-downs are enabled.
// - In UART mode the ring indicator input is the wake input.
// - With no other mode selected, run as UART.
// - After each reset load config memory and enter its mode.
// - Host bit-mode command selects bit-bang or serial engine modes.
// - Value 0x40 gives sync FIFO only if config chose FIFO.
// - Pin drive, slew and Schmitt come from config memory.
// - In fast serial mode host may only reset or release controller.
// - Bit-mode 0x10 holds fast serial in reset; 0x00 releases.
module msi_top
   import msi_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Configuration memory word, stable around reset release
   input wire logic [CFG_W-1:0] cfg_word_i,
   // Pins
   input wire logic flush_wake_req_n_i,
   input wire logic ring_indicator_n_i,
   input wire logic suspended_i,
   // Results
   output msi_mode_e mode_o,
   output logic [1:0] drive_sel_o,
   output logic slew_slow_o,
   output logic schmitt_en_o,
   output logic pulldown_en_o,
   output logic fs_reset_o,
   output logic flush_o,
   output logic wake_o,
   output logic cfg_done_o
);
   typedef struct packed {
      logic [2:0] fw_sync;
      logic [2:0] ring_sync;
      logic [CNT_W-1:0] low_cnt;
      logic wake_sent;
      logic [2:0] load_cnt;
      logic done;
      msi_mode_e mode;
      logic fs_hold;
      logic [7:0] last_bm;
      logic flush;
      logic wake;
      logic ack;
      logic [31:0] rdata;
   } msi_state_s;
   msi_state_s r, next_r;

   msi_cfg_if cfg_bus();

   msi_cfg_store u_msi_cfg_store (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .cfg(cfg_bus)
   );

   // Decode of the configuration mode field
   function automatic msi_mode_e cfg_to_mode(input logic [CFG_W-1:0] w);
      case (w[CFG_MODE_LSB +: CFG_MODE_W])
         CFG_SEL_FIFO: cfg_to_mode = MSI_MODE_ASYNC_FIFO;
         CFG_SEL_CPU: cfg_to_mode = MSI_MODE_CPU_FIFO;
         CFG_SEL_HALF: cfg_to_mode = MSI_MODE_HALF_DUPLEX;
         CFG_SEL_FAST: cfg_to_mode = MSI_MODE_FAST_SERIAL;
         default: cfg_to_mode = MSI_MODE_UART;
      endcase
   endfunction

   // Whether the flush/wake input is offered in a mode
   function automatic logic fw_offered(input msi_mode_e m);
      case (m)
         MSI_MODE_ASYNC_FIFO, MSI_MODE_SYNC_FIFO, MSI_MODE_CPU_FIFO,
         MSI_MODE_ASYNC_BITBANG, MSI_MODE_SYNC_BITBANG: fw_offered = 1'b1;
         default: fw_offered = 1'b0;
      endcase
   endfunction

   logic cfg_fifo;
   logic [7:0] bm_val;
   logic wr_acc;
   logic rd_acc;
   logic fw_fall;
   logic wake_src_n;
   logic offered;

   assign cfg_fifo = cfg_to_mode(cfg_bus.rdata) == MSI_MODE_ASYNC_FIFO;
   assign bm_val = avs_writedata[7:0];
   // Writes land in the cycle waitrequest is low, the edge the master releases on
   assign wr_acc = avs_write && r.ack;
   assign rd_acc = avs_read && !r.ack;
   assign offered = fw_offered(r.mode) && r.done;

   // Wake source: ring indicator in UART mode, else flush/wake pin
   assign wake_src_n = (r.mode == MSI_MODE_UART) ? r.ring_sync[1] : r.fw_sync[1];
   // Only second and third stages are looked at; first stage feeds second only
   assign fw_fall = r.fw_sync[2] && !r.fw_sync[1];

   // Configuration load handshake to the store
   assign cfg_bus.load = !r.done && (r.load_cnt == 3'(LOAD_CYCLES - 1));
   assign cfg_bus.wdata = cfg_word_i;

   // Next-state logic
   always_comb begin
      next_r = r;
      next_r.flush = 1'b0;
      next_r.wake = 1'b0;
      next_r.ack = 1'b0;
      // Two flip-flops before use, third for edge detection
      next_r.fw_sync = {r.fw_sync[1:0], flush_wake_req_n_i};
      next_r.ring_sync = {r.ring_sync[1:0], ring_indicator_n_i};

      // Configuration fetch after reset
      if (!r.done) begin
         next_r.load_cnt = r.load_cnt + 3'h1;
         if (r.load_cnt == 3'(LOAD_CYCLES)) begin
            next_r.done = 1'b1;
            next_r.mode = cfg_to_mode(cfg_bus.rdata);
         end
      end

      // Flush: falling edge while offered gives a one-cycle request
      if (offered && fw_fall) begin
         next_r.flush = 1'b1;
      end

      // Wake: hold low long enough while suspended; a short pulse only flushes
      if (!wake_src_n && (offered || r.mode == MSI_MODE_UART) && r.done) begin
         if (r.low_cnt != CNT_W'(WAKE_CYCLES)) begin
            next_r.low_cnt = r.low_cnt + CNT_W'(1);
         end
      end else begin
         next_r.low_cnt = '0;
         next_r.wake_sent = 1'b0;
      end
      if (r.low_cnt == CNT_W'(WAKE_CYCLES) && !r.wake_sent && suspended_i) begin
         next_r.wake_sent = 1'b1;
         // Pull-downs would load the pin in suspend, so wake is refused
         next_r.wake = !cfg_bus.rdata[CFG_PULLDN_BIT];
      end

      // Avalon access: one wait state, answer in the following cycle
      if (avs_read || avs_write) begin
         next_r.ack = !r.ack;
      end
      if (wr_acc && avs_address == REG_BITMODE && avs_byteenable[0] && r.done) begin
         next_r.last_bm = bm_val;
         if (r.mode == MSI_MODE_FAST_SERIAL) begin
            // Only hold and release are honoured here
            if (bm_val == BM_FS_HOLD) next_r.fs_hold = 1'b1;
            else if (bm_val == BM_RESET) next_r.fs_hold = 1'b0;
         end else begin
            case (bm_val)
               BM_RESET: next_r.mode = cfg_to_mode(cfg_bus.rdata);
               BM_ASYNC_BB: next_r.mode = MSI_MODE_ASYNC_BITBANG;
               BM_SYNC_BB: next_r.mode = MSI_MODE_SYNC_BITBANG;
               BM_SERIAL_ENGINE: next_r.mode = MSI_MODE_SERIAL_ENGINE;
               BM_SYNC_FIFO: begin
                  if (cfg_fifo) next_r.mode = MSI_MODE_SYNC_FIFO;
               end
               default: next_r.mode = r.mode;
            endcase
         end
      end
      if (rd_acc) begin
         case (avs_address)
            REG_CFG: next_r.rdata = {24'h000000, cfg_bus.rdata};
            REG_BITMODE: next_r.rdata = {24'h000000, r.last_bm};
            REG_STATUS: next_r.rdata = {22'h000000, r.fs_hold, r.done, 4'h0,
                                        4'(r.mode)};
            REG_SUSPEND: next_r.rdata = {31'h00000000, suspended_i};
            default: next_r.rdata = REG_UNMAPPED;
         endcase
      end
   end

   // State register; synchronisers reset high to the idle level
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         r <= '{fw_sync: 3'h7, ring_sync: 3'h7, low_cnt: '0, wake_sent: 1'b0,
                load_cnt: 3'h0, done: 1'b0, mode: MSI_MODE_UART, fs_hold: 1'b0,
                last_bm: 8'h00, flush: 1'b0, wake: 1'b0, ack: 1'b0,
                rdata: 32'h00000000};
      end else begin
         r <= next_r;
      end
   end

   // Outputs
   assign avs_waitrequest = (avs_read || avs_write) && !r.ack;
   assign avs_readdata = r.rdata;
   assign mode_o = r.mode;
   assign drive_sel_o = cfg_bus.rdata[CFG_DRIVE_LSB +: 2];
   assign slew_slow_o = cfg_bus.rdata[CFG_SLEW_BIT];
   assign schmitt_en_o = cfg_bus.rdata[CFG_SCHMITT_BIT];
   assign pulldown_en_o = cfg_bus.rdata[CFG_PULLDN_BIT];
   assign fs_reset_o = r.fs_hold;
   assign flush_o = r.flush;
   assign wake_o = r.wake;
   assign cfg_done_o = r.done;

   // Flush pulse only follows a synchronised falling edge in an offered mode
   chk_flush_cause: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      flush_o |-> $past(offered) && $past(fw_fall))
      else $error("flush without an offered falling edge");
   // Every offered falling edge yields a flush next cycle
   chk_flush_edge: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (offered && fw_fall) |=> flush_o)
      else $error("falling edge did not flush");
   // Input ignored in UART mode
   chk_flush_ignored: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (r.mode == MSI_MODE_UART) && (mode_o == MSI_MODE_UART) |=> !flush_o)
      else $error("flush raised in uart mode");
   // Wake never raised with pull-downs enabled
   chk_wake_pulldown: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      pulldown_en_o |-> !wake_o)
      else $error("wake raised with pull-downs");
   // Configuration completes within a bounded time after reset
   chk_cfg_done: assert property (@(posedge ref_clk_i)
      $fell(reset_i) |-> ##[1:8] cfg_done_o)
      else $error("configuration load too slow");
   // Hold value keeps fast serial in reset
   chk_fs_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (wr_acc && avs_address == REG_BITMODE && avs_byteenable[0] && r.done
       && mode_o == MSI_MODE_FAST_SERIAL && bm_val == BM_FS_HOLD) |=> fs_reset_o)
      else $error("fast serial not held");
   // Mode never leaves fast serial through a host command
   chk_fs_locked: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (mode_o == MSI_MODE_FAST_SERIAL && r.done) |=> mode_o == MSI_MODE_FAST_SERIAL)
      else $error("fast serial mode changed");
   // Sync FIFO only reachable when configured for FIFO
   chk_sync_fifo: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (mode_o == MSI_MODE_SYNC_FIFO) |-> cfg_fifo)
      else $error("sync fifo without fifo config");
   // Mode stable without a bit-mode write
   chk_mode_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (cfg_done_o && !(wr_acc && avs_address == REG_BITMODE)) |=> $stable(mode_o))
      else $error("mode changed without command");
   // In UART mode a low ring indicator advances the wake count
   chk_ring_wake_count: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (r.done && r.mode == MSI_MODE_UART && !r.ring_sync[1]) |=> r.low_cnt != '0)
      else $error("ring indicator not counted in uart mode");
endmodule // msi_top

/* verif/msi_periph_model.sv */
// Peripheral-side model driving the flush/wake and ring indicator pins.
// Assumes the bench calls its tasks right after a rising edge of ref_clk_i.
`timescale 1ns/1ps
module msi_periph_model
   import msi_pkg::*;
(
   input wire logic ref_clk_i,
   output logic flush_wake_req_n_o,
   output logic ring_indicator_n_o
);
   // Pins rest high between requests
   initial begin
      flush_wake_req_n_o = 1'b1;
      ring_indicator_n_o = 1'b1;
   end
   // Low pulse rounded up to whole cycles, so it is never shorter than asked
   task automatic pulse_low(input longint ns);
      longint cyc;
      begin
         cyc = (ns * CLK_MHZ + 999) / 1000;
         flush_wake_req_n_o <= 1'b0;
         repeat (cyc) @(posedge ref_clk_i);
         flush_wake_req_n_o <= 1'b1;
      end
   endtask
   // Callers flush only once writing has stopped, so nothing is overrun
   task automatic send_flush();
      pulse_low(FLUSH_PULSE_NS);
   endtask
   // Ring indicator low for some cycles; far shorter than any wake pulse
   task automatic ring_low(input int cyc);
      ring_indicator_n_o <= 1'b0;
      repeat (cyc) @(posedge ref_clk_i);
      ring_indicator_n_o <= 1'b1;
   endtask
   // Wake pulse; too long for the regular run, kept for completeness
   task automatic send_wake();
      pulse_low(longint'(WAKE_PULSE_MS) * 1000000);
   endtask
endmodule // msi_periph_model

/* verif/testbench.sv */
// Self-checking bench for the mode select and send-immediate block.
// Assumes the peripheral model in msi_periph_model and one 125 MHz clock.
`timescale 1ns/1ps
module testbench
   import msi_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] cfg_word_i = 8'h00;
   logic flush_wake_req_n_i;
   logic ring_indicator_n_i;
   logic suspended_i = 1'b0;
   msi_mode_e mode_o;
   logic [1:0] drive_sel_o;
   logic slew_slow_o, schmitt_en_o, pulldown_en_o, fs_reset_o, flush_o, wake_o, cfg_done_o;
   int failures = 0;
   int n_compared = 0;
   int n_flush = 0;
   int n_wake = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic [7:0] cfgs [6] = '{8'h00, 8'h31, 8'h02, 8'h03, 8'hc4, 8'h07};
   msi_mode_e cfg_exp [6] = '{MSI_MODE_UART, MSI_MODE_ASYNC_FIFO, MSI_MODE_CPU_FIFO,
      MSI_MODE_HALF_DUPLEX, MSI_MODE_FAST_SERIAL, MSI_MODE_UART};
   logic [7:0] bms [6] = '{8'h01, 8'h04, 8'h02, 8'h40, 8'h00, 8'h33};
   msi_mode_e bm_exp [6] = '{MSI_MODE_ASYNC_BITBANG, MSI_MODE_SYNC_BITBANG, MSI_MODE_SERIAL_ENGINE,
      MSI_MODE_SYNC_FIFO, MSI_MODE_ASYNC_FIFO, MSI_MODE_ASYNC_FIFO};

   msi_top u_msi_top (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cfg_word_i(cfg_word_i),
      .flush_wake_req_n_i(flush_wake_req_n_i), .ring_indicator_n_i(ring_indicator_n_i),
      .suspended_i(suspended_i), .mode_o(mode_o), .drive_sel_o(drive_sel_o),
      .slew_slow_o(slew_slow_o), .schmitt_en_o(schmitt_en_o), .pulldown_en_o(pulldown_en_o),
      .fs_reset_o(fs_reset_o), .flush_o(flush_o), .wake_o(wake_o), .cfg_done_o(cfg_done_o));
   msi_periph_model u_msi_periph_model (.ref_clk_i(ref_clk_i),
      .flush_wake_req_n_o(flush_wake_req_n_i), .ring_indicator_n_o(ring_indicator_n_i));

   // 8 ns clock
   always #4 ref_clk_i = ~ref_clk_i;
   // Flush pulse counter and a watchdog well above the expected run length
   always @(posedge ref_clk_i) begin
      if (flush_o === 1'b1) n_flush <= n_flush + 1;
      if (wake_o === 1'b1) n_wake <= n_wake + 1;
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Avalon transfers hold everything until waitrequest is seen low at an edge
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= 1'b1;
      do @(posedge ref_clk_i); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge ref_clk_i); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   // Reset with a given config word; loading is done by the fifth edge
   task automatic do_reset(input logic [7:0] cfg);
      cfg_word_i <= cfg;
      reset_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      check(cfg_done_o, 1'b1, "config done");
   endtask
   function automatic logic offered(input msi_mode_e m);
      return m inside {MSI_MODE_ASYNC_FIFO, MSI_MODE_SYNC_FIFO, MSI_MODE_CPU_FIFO,
         MSI_MODE_ASYNC_BITBANG, MSI_MODE_SYNC_BITBANG};
   endfunction
   task automatic try_flush(input msi_mode_e m);
      n_flush = 0;
      u_msi_periph_model.send_flush();
      repeat (8) @(posedge ref_clk_i);
      check(n_flush, offered(m) ? 1 : 0, "flush pulses");
   endtask

   // Main sequence
   initial begin
      for (int i = 0; i < 6; i++) begin
         do_reset(cfgs[i]);
         check(mode_o, cfg_exp[i], "config mode");
         check(drive_sel_o, cfgs[i][CFG_DRIVE_LSB +: 2], "drive");
         check(slew_slow_o, cfgs[i][CFG_SLEW_BIT], "slew");
         check(schmitt_en_o, cfgs[i][CFG_SCHMITT_BIT], "schmitt");
         check(pulldown_en_o, cfgs[i][CFG_PULLDN_BIT], "pull-down");
         check(fs_reset_o, 1'b0, "fast serial held");
         try_flush(cfg_exp[i]);
      end
      bus_wr(REG_BITMODE, BM_SYNC_FIFO);
      check(mode_o, MSI_MODE_UART, "sync fifo from uart");
      // Host suspended from here on; short pulses must never wake it
      suspended_i <= 1'b1;
      n_flush = 0;
      u_msi_periph_model.ring_low(40);
      repeat (8) @(posedge ref_clk_i);
      check(n_flush, 0, "ring indicator flush");
      do_reset(8'h31);
      bus_rd(REG_CFG, rd);
      check(rd, 32'h00000031, "config word");
      bus_rd(REG_SUSPEND, rd);
      check(rd, 32'h00000001, "suspend state");
      for (int i = 0; i < 6; i++) begin
         bus_wr(REG_BITMODE, bms[i]);
         check(mode_o, bm_exp[i], "bit mode");
         bus_rd(REG_STATUS, rd);
         check(rd[8:0], {1'b1, 4'h0, 4'(bm_exp[i])}, "status");
         try_flush(bm_exp[i]);
      end
      bus_rd(4'h2, rd);
      check(rd, 32'h0, "unmapped read");
      bus_wr(4'h1, BM_ASYNC_BB);
      check(mode_o, MSI_MODE_ASYNC_FIFO, "unmapped write");
      do_reset(8'h04);
      bus_wr(REG_BITMODE, BM_ASYNC_BB);
      check(mode_o, MSI_MODE_FAST_SERIAL, "fast serial locked");
      bus_wr(REG_BITMODE, BM_FS_HOLD);
      check(fs_reset_o, 1'b1, "fast serial hold");
      bus_rd(REG_STATUS, rd);
      check(rd[9], 1'b1, "status hold bit");
      bus_wr(REG_BITMODE, BM_RESET);
      check(fs_reset_o, 1'b0, "fast serial release");
      check(mode_o, MSI_MODE_FAST_SERIAL, "fast serial kept");
      check(n_wake, 0, "wake from short pulses");
      complete_run();
   end
endmodule // testbench
